// file: logic/rxbsh_defines.svh
/*
  Constants for the receive buffer status handshake block: field positions,
  codes and baud timing. Assumes a 100 MHz core clock.
*/
// Functional notes
// - the device writes a nonzero status word when it has filled a buffer.
// - an improper host clear raises the receive error in the error status.
// - status zero means empty, and only the host writes that zero.
// - in FSK parallel mode one bit is sampled per baud at 1200, 300 or 75.
// - sync and HDLC modes report 1 to 8 valid bytes in bits 3:0.
// - HDLC mode puts an error code in 5:4, start in bit 6, end in bit 7.
// - no transmit exchange starts before the transmit start command.
// - after filling, the device writes status then pulses the interrupt.
// - the device checks a buffer is free right before it fills it.
`ifndef RXBSH_DEFINES_SVH
`define RXBSH_DEFINES_SVH
`define RXBSH_LEN_LSB 0
`define RXBSH_LEN_MSB 3
`define RXBSH_ERR_LSB 4
`define RXBSH_ERR_MSB 5
`define RXBSH_SFRM_BIT 6
`define RXBSH_EFRM_BIT 7
`define RXBSH_ERR_NONE 2'h0
`define RXBSH_ERR_CRC 2'h1
`define RXBSH_ERR_ALIGN 2'h2
`define RXBSH_ERR_ABORT 2'h3
`define RXBSH_MAX_BYTES 8
`define RXBSH_CLK_HZ 100000000
`define RXBSH_BAUD_HI 1200
`define RXBSH_BAUD_MID 300
`define RXBSH_BAUD_LO 75
`define RXBSH_RESET_STATUS 8'h00
`endif

// file: logic/rxbsh_pkg.sv
/*
  Types for the receive buffer status handshake block.
  Assumes rxbsh_defines.svh is compiled alongside.
*/
package rxbsh_pkg;
  typedef enum logic [1:0] {
    RXBSH_SYNC = 2'h0,
    RXBSH_HDLC = 2'h1,
    RXBSH_FSK = 2'h3
  } rxbsh_mode_t;
  typedef enum logic [1:0] {
    RXBSH_B1200 = 2'h0,
    RXBSH_B300 = 2'h1,
    RXBSH_B75 = 2'h2
  } rxbsh_baud_t;
  typedef enum logic [1:0] {
    RXBSH_IDLE = 2'h0,
    RXBSH_FILL = 2'h1,
    RXBSH_POST = 2'h3
  } rxbsh_state_t;
endpackage

// file: logic/rxbsh_baud.sv
/*
  Baud-rate bit sampler for FSK parallel receive: samples the line once per
  nominal baud period. Assumes a synchronised line and the 100 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rxbsh_defines.svh"
module rxbsh_baud
  import rxbsh_pkg::*;
#(
  parameter int CLK_HZ = `RXBSH_CLK_HZ
) (
  input wire logic clk, // core clock
  input wire logic reset, // async reset
  input wire logic ce, // clock enable
  input wire logic run, // sampler active
  input wire rxbsh_pkg::rxbsh_baud_t baud, // selected rate
  input wire logic line, // synchronised data line
  output logic bit_stb, // one-cycle sample strobe
  output logic bit_val // sampled bit
);
  localparam int P_HI = CLK_HZ / `RXBSH_BAUD_HI;
  localparam int P_MID = CLK_HZ / `RXBSH_BAUD_MID;
  localparam int P_LO = CLK_HZ / `RXBSH_BAUD_LO;
  logic [21:0] cnt_r;
  logic [21:0] period;
  always_comb begin
    unique case (baud)
      RXBSH_B300: period = 22'(P_MID);
      RXBSH_B75: period = 22'(P_LO);
      default: period = 22'(P_HI);
    endcase
  end
  // counter restarts at half a period so samples land mid-bit
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cnt_r <= 22'h0;
      bit_stb <= 1'b0;
      bit_val <= 1'b0;
    end else if (ce) begin
      bit_stb <= 1'b0;
      if (!run) begin
        cnt_r <= period >> 1;
      end else if (cnt_r == 22'h0) begin
        cnt_r <= period - 22'h1;
        bit_stb <= 1'b1;
        bit_val <= line;
      end else begin
        cnt_r <= cnt_r - 22'h1;
      end
    end
  end
  // shortest period is CLK_HZ/1200, eight clocks at the bench's 9600 Hz, so at least seven quiet cycles follow a strobe
  a_baud_period: assert property (@(posedge clk)
    disable iff (reset) $rose(bit_stb) && ce && run |=> !bit_stb [*7])
    else $error("bit strobe repeated within a baud period");
endmodule
`default_nettype wire

// file: logic/rxbsh_top.sv
/*
  Receive buffer status handshake: fills two alternating receive buffers,
  writes their status words into the shared memory, raises the buffer-full
  interrupt and flags improper clears by the host. Assumes the host port of
  the dual-port memory reports status writes on HOST_WR_* and the deframer
  delivers bytes on RX_BYTE_* with frame markers.
*/
`timescale 1ns/1ns
`default_nettype none
`include "rxbsh_defines.svh"
module rxbsh_top
  import rxbsh_pkg::*;
#(
  parameter int NBYTES = `RXBSH_MAX_BYTES,
  parameter int CLK_HZ = `RXBSH_CLK_HZ
) (
  input wire logic CLK, // core clock
  input wire logic RESET, // async reset, high
  input wire logic CE, // clock enable
  input wire rxbsh_pkg::rxbsh_mode_t MODE, // data format
  input wire rxbsh_pkg::rxbsh_baud_t BAUD, // fsk baud rate
  input wire logic FSK_LINE, // fsk data pin
  input wire logic RX_BYTE_VALID, // deframed byte ready
  input wire logic [7:0] RX_BYTE, // deframed byte
  input wire logic RX_FRAME_START, // byte opens a frame
  input wire logic RX_FRAME_END, // byte closes a frame
  input wire logic [1:0] RX_FRAME_ERR, // frame error code with end
  output logic RX_BYTE_READY, // deframer may send
  input wire logic HOST_WR, // host writes a status word
  input wire logic HOST_WR_SEL, // which status word
  input wire logic [7:0] HOST_WR_DATA, // value written
  input wire logic TRANSMIT_START_COMMAND, // host transmit command
  output logic TX_ENABLE, // transmit exchanges allowed
  output logic [7:0] RECEIVE_BUFFER0_STATUS, // status word 0
  output logic [7:0] RECEIVE_BUFFER1_STATUS, // status word 1
  output logic DATA_WE, // data byte write to memory
  output logic DATA_BUF, // buffer of that byte
  output logic [2:0] DATA_IDX, // byte index
  output logic [7:0] DATA_OUT, // byte value
  output logic RECEIVE_BUFFER_FULL_IRQ, // one-cycle full pulse
  output logic SYSTEM_ERROR_RX // receive error, sticky
);
  logic [7:0] status_r [2];
  rxbsh_state_t state_r;
  logic buf_r;
  logic [3:0] cnt_r;
  logic [7:0] stat_nxt;
  logic sfrm_r;
  logic err_r;
  logic [7:0] shift_r;
  logic [2:0] bits_r;
  logic line_s1_r;
  logic line_s2_r;
  logic bit_stb;
  logic bit_val;
  logic fsk;
  logic in_valid;
  logic [7:0] in_byte;
  logic full_now;
  logic dev_write;

  assign fsk = (MODE == RXBSH_FSK);
  assign RECEIVE_BUFFER0_STATUS = status_r[0];
  assign RECEIVE_BUFFER1_STATUS = status_r[1];
  assign RX_BYTE_READY = (state_r == RXBSH_FILL) && !fsk;

  // two-flop synchroniser for the fsk line pin
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      line_s1_r <= 1'b0;
      line_s2_r <= 1'b0;
    end else if (CE) begin
      line_s1_r <= FSK_LINE;
      line_s2_r <= line_s1_r;
    end
  end

  rxbsh_baud #(.CLK_HZ(CLK_HZ)) u_baud (
    .clk(CLK),
    .reset(RESET),
    .ce(CE),
    .run(fsk),
    .baud(BAUD),
    .line(line_s2_r),
    .bit_stb(bit_stb),
    .bit_val(bit_val)
  );

  // fsk bits assembled lsb first into bytes
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      shift_r <= 8'h00;
      bits_r <= 3'h0;
    end else if (CE && fsk && bit_stb) begin
      shift_r <= {bit_val, shift_r[7:1]};
      bits_r <= bits_r + 3'h1;
    end
  end

  // fsk bytes arriving with no free buffer are dropped, as on real line
  assign in_valid = fsk ? (bit_stb && bits_r == 3'h7) : RX_BYTE_VALID;
  assign in_byte = fsk ? {bit_val, shift_r[7:1]} : RX_BYTE;
  assign full_now = (state_r == RXBSH_FILL) && in_valid &&
                    ((cnt_r == 4'(NBYTES - 1)) ||
                     (MODE == RXBSH_HDLC && RX_FRAME_END));

  // status word assembled from count and hdlc frame fields
  always_comb begin
    stat_nxt = `RXBSH_RESET_STATUS;
    stat_nxt[`RXBSH_LEN_MSB:`RXBSH_LEN_LSB] = cnt_r + 4'h1;
    if (MODE == RXBSH_HDLC) begin
      stat_nxt[`RXBSH_SFRM_BIT] = sfrm_r | RX_FRAME_START;
      stat_nxt[`RXBSH_EFRM_BIT] = RX_FRAME_END;
      if (RX_FRAME_END) begin
        stat_nxt[`RXBSH_ERR_MSB:`RXBSH_ERR_LSB] = RX_FRAME_ERR;
      end
    end
  end

  // fill sequencer: wait free, fill, post status
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      state_r <= RXBSH_IDLE;
      buf_r <= 1'b0;
      cnt_r <= 4'h0;
      sfrm_r <= 1'b0;
    end else if (CE) begin
      unique case (state_r)
        RXBSH_IDLE: begin
          // free check just before filling
          if (status_r[buf_r] == 8'h00) begin
            state_r <= RXBSH_FILL;
            cnt_r <= 4'h0;
            sfrm_r <= 1'b0;
          end
        end
        RXBSH_FILL: begin
          if (full_now) begin
            state_r <= RXBSH_POST;
          end else if (in_valid) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h0 && RX_FRAME_START && MODE == RXBSH_HDLC) begin
              sfrm_r <= 1'b1;
            end
          end
        end
        RXBSH_POST: begin
          state_r <= RXBSH_IDLE;
          buf_r <= ~buf_r;
        end
      endcase
    end
  end

  assign dev_write = CE && full_now;

  // status words: device posts nonzero, host clears to zero
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      status_r[0] <= `RXBSH_RESET_STATUS;
      status_r[1] <= `RXBSH_RESET_STATUS;
    end else if (CE) begin
      if (HOST_WR && HOST_WR_DATA == 8'h00) begin
        status_r[HOST_WR_SEL] <= 8'h00;
      end
      // device write is later so it wins a same-cycle clash
      if (full_now) begin
        status_r[buf_r] <= stat_nxt;
      end
    end
  end

  // improper clear: nonzero write, or clearing an already empty word
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      err_r <= 1'b0;
    end else if (CE && HOST_WR) begin
      if (HOST_WR_DATA != 8'h00 || status_r[HOST_WR_SEL] == 8'h00) begin
        err_r <= 1'b1;
      end
    end
  end
  assign SYSTEM_ERROR_RX = err_r;

  // data port writes as bytes arrive, and interrupt one cycle after status posting
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      DATA_WE <= 1'b0;
      DATA_BUF <= 1'b0;
      DATA_IDX <= 3'h0;
      DATA_OUT <= 8'h00;
      RECEIVE_BUFFER_FULL_IRQ <= 1'b0;
    end else if (CE) begin
      DATA_WE <= (state_r == RXBSH_FILL) && in_valid;
      DATA_BUF <= buf_r;
      DATA_IDX <= cnt_r[2:0];
      DATA_OUT <= in_byte;
      RECEIVE_BUFFER_FULL_IRQ <= (state_r == RXBSH_POST);
    end
  end

  // transmit gate opens only on the host command
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      TX_ENABLE <= 1'b0;
    end else if (CE && TRANSMIT_START_COMMAND) begin
      TX_ENABLE <= 1'b1;
    end
  end

  sequence s_post;
    CE && full_now ##1 CE && state_r == RXBSH_POST;
  endsequence
  a_irq_after_post: assert property (@(posedge CLK)
    disable iff (RESET) s_post |=> RECEIVE_BUFFER_FULL_IRQ)
    else $error("interrupt missing after status post");
  a_post_nonzero: assert property (@(posedge CLK)
    disable iff (RESET) dev_write |=> status_r[$past(buf_r)] != 8'h00)
    else $error("posted status word is zero");
  a_count_range: assert property (@(posedge CLK)
    disable iff (RESET) dev_write && MODE != RXBSH_FSK |=>
      status_r[$past(buf_r)][3:0] inside {[4'h1:4'h8]})
    else $error("byte count out of range");
  a_no_fill_busy: assert property (@(posedge CLK)
    disable iff (RESET)
    $rose(state_r == RXBSH_FILL) |-> $past(status_r[buf_r]) == 8'h00)
    else $error("fill started on a busy buffer");
  a_alternate: assert property (@(posedge CLK)
    disable iff (RESET)
    CE && state_r == RXBSH_POST |=> buf_r != $past(buf_r))
    else $error("buffers not alternated");
  a_err_on_bad: assert property (@(posedge CLK)
    disable iff (RESET)
    CE && HOST_WR && HOST_WR_DATA != 8'h00 |=> SYSTEM_ERROR_RX)
    else $error("improper clear not flagged");
  a_host_clear: assert property (@(posedge CLK)
    disable iff (RESET)
    CE && HOST_WR && HOST_WR_DATA == 8'h00 && !full_now
      |=> status_r[$past(HOST_WR_SEL)] == 8'h00)
    else $error("host clear lost");
  a_tx_gate: assert property (@(posedge CLK)
    disable iff (RESET) $rose(TX_ENABLE) |-> $past(TRANSMIT_START_COMMAND))
    else $error("transmit enabled without command");
  a_eof_flag: assert property (@(posedge CLK)
    disable iff (RESET) dev_write && MODE == RXBSH_HDLC && RX_FRAME_END
      |=> status_r[$past(buf_r)][7])
    else $error("end of frame flag missing");
endmodule
`default_nettype wire

// file: testbench/rxbsh_host_model.sv
/*
  Host processor model for the receive status handshake: clears each
  status word in turn after the buffer-full pulse.
  Assumes the block's one-cycle interrupt and the CLK domain.
*/
`timescale 1ns/1ns
`default_nettype none
module rxbsh_host_model (
  input wire logic clk, // core clock
  input wire logic reset, // async reset
  input wire logic irq, // buffer-full pulse
  input wire logic hold, // stall: leave buffers unread
  input wire logic bad, // write a nonzero value instead of zero
  input wire logic [7:0] delay, // cycles spent consuming a buffer
  output logic wr, // status write strobe
  output logic sel, // status word chosen
  output logic [7:0] data // value written
);
  logic [1:0] pend;
  logic [7:0] wait_c;
  // one write per filled buffer, words taken in fixed order
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      wr <= 1'b0;
      sel <= 1'b0;
      data <= 8'h00;
      pend <= 2'h0;
      wait_c <= 8'h00;
    end else begin
      wr <= 1'b0;
      data <= ~data; // released bus shows no stale value
      pend <= pend + {1'b0, irq} - {1'b0, wr};
      if (wr) begin
        sel <= ~sel;
      end
      if (pend != 2'h0 && !hold && !wr) begin
        if (wait_c < delay) begin
          wait_c <= wait_c + 8'h01;
        end else begin
          wr <= 1'b1;
          data <= bad ? 8'h5a : 8'h00;
          wait_c <= 8'h00;
        end
      end
    end
  end
endmodule
`default_nettype wire

// file: testbench/rx_buffer_status_handshake_bench.sv
/*
  Self-checking bench: deframer bytes in, host model clearing status.
  Assumes rxbsh_pkg and the host model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module rx_buffer_status_handshake_bench;
  import rxbsh_pkg::*;
  logic CLK, RESET, VLD, SOF, EOF, RDY, TXC, TXE, WE, BUF, IRQ, ERR;
  logic hold, bad, HWR, HSEL, nb;
  logic [1:0] FERR;
  logic [2:0] IDX;
  logic [7:0] BYTE, S0, S1, HDAT, DOUT, dly;
  rxbsh_mode_t mode;
  rxbsh_baud_t baud;
  logic CE, LINE;
  int fail_count, samples_checked;
  int fsk_n = 0;
  // scaled clock keeps a baud period to a few clocks in simulation
  localparam int TB_HZ = 9600;
  // fsk byte sent lsb first on the line
  localparam logic [7:0] FSK_PAT = 8'h35;
  rxbsh_top #(.CLK_HZ(TB_HZ)) dut (.CLK(CLK), .RESET(RESET), .CE(CE),
    .MODE(mode), .BAUD(baud), .FSK_LINE(LINE), .RX_BYTE_VALID(VLD),
    .RX_BYTE(BYTE), .RX_FRAME_START(SOF), .RX_FRAME_END(EOF),
    .RX_FRAME_ERR(FERR), .RX_BYTE_READY(RDY), .HOST_WR(HWR),
    .HOST_WR_SEL(HSEL), .HOST_WR_DATA(HDAT), .TRANSMIT_START_COMMAND(TXC),
    .TX_ENABLE(TXE), .RECEIVE_BUFFER0_STATUS(S0),
    .RECEIVE_BUFFER1_STATUS(S1), .DATA_WE(WE), .DATA_BUF(BUF),
    .DATA_IDX(IDX), .DATA_OUT(DOUT), .RECEIVE_BUFFER_FULL_IRQ(IRQ),
    .SYSTEM_ERROR_RX(ERR));
  rxbsh_host_model host (.clk(CLK), .reset(RESET), .irq(IRQ), .hold(hold),
    .bad(bad), .delay(dly), .wr(HWR), .sel(HSEL), .data(HDAT));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // bounded wait on a flag sampled at the falling edge
  task automatic wait_on(input int which);
    int n;
    n = 0;
    while (n < 2000 && !(which == 0 ? RDY === 1'b1 : which == 1 ?
        IRQ === 1'b1 : which == 2 ? ERR === 1'b1 : (S0 | S1) === 8'h00)) begin
      @(negedge CLK);
      n++;
    end
    if (n >= 2000) begin
      fail_count++;
      results;
    end
  endtask
  task automatic send(input logic [7:0] b, input logic s, input logic e,
      input logic [1:0] er);
    wait_on(0);
    VLD = 1'b1;
    BYTE = b;
    SOF = s;
    EOF = e;
    FERR = er;
    @(negedge CLK);
    // valid stays up for a following byte; the byte value is its index
    chk({7'h00, WE}, 8'h01);
    chk(DOUT, b);
    chk({5'h00, IDX}, {5'h00, b[2:0]});
    chk({7'h00, BUF}, {7'h00, nb});
  endtask
  // eight back-to-back bytes close a sync buffer, then check its word
  task automatic fill8;
    for (int i = 0; i < 8; i++) send(8'(i), 1'b0, 1'b0, 2'h0);
    VLD = 1'b0;
    wait_on(1);
    chk(nb ? S1 : S0, 8'h08);
    nb = ~nb;
    @(negedge CLK);
  endtask
  // every fsk byte written to memory carries the line pattern
  always @(negedge CLK) begin
    if (mode == RXBSH_FSK && WE === 1'b1) begin
      chk(DOUT, FSK_PAT);
      fsk_n++;
    end
  end
  // eight fsk bytes at one rate; host held off so the word can be read
  task automatic fsk8(input rxbsh_baud_t b, input int per);
    int n0;
    n0 = fsk_n;
    hold = 1'b1;
    baud = b;
    @(negedge CLK);
    mode = RXBSH_FSK;
    for (int i = 0; i < 64; i++) begin
      LINE = FSK_PAT[i % 8];
      repeat (per) @(negedge CLK);
    end
    mode = RXBSH_SYNC;
    chk(8'(fsk_n - n0), 8'h08);
    chk(nb ? S1 : S0, 8'h08);
    nb = ~nb;
    hold = 1'b0;
    wait_on(3);
  endtask
  initial begin
    {VLD, SOF, EOF, TXC, hold, bad, nb} = '0;
    CE = 1'b1;
    LINE = 1'b1;
    baud = RXBSH_B1200;
    FERR = 2'h0;
    BYTE = 8'h00;
    dly = 8'h01;
    mode = RXBSH_SYNC;
    fail_count = 0;
    samples_checked = 0;
    RESET = 1'b1;
    repeat (4) @(negedge CLK);
    RESET = 1'b0;
    chk(S0 | S1, 8'h00);
    chk({6'h00, TXE, ERR}, 8'h00);
    // transmit gate stays shut until the host command is issued
    TXC = 1'b1;
    @(negedge CLK);
    TXC = 1'b0;
    chk(TXE, 1'b1);
    fill8;
    fill8;
    // every frame error code, frame lengths 1 to 4, slow host
    mode = RXBSH_HDLC;
    dly = 8'd40;
    for (int e = 0; e < 4; e++) begin
      for (int i = 0; i <= e; i++) send(8'(i), i == 0, i == e, 2'(e));
      {VLD, SOF, EOF} = 3'b000;
      wait_on(1);
      chk(nb ? S1 : S0, {2'b11, 2'(e), 4'(e + 1)});
      nb = ~nb;
      @(negedge CLK);
    end
    // host stalls: both buffers full, no third fill may start
    mode = RXBSH_SYNC;
    wait_on(3);
    hold = 1'b1;
    fill8;
    fill8;
    repeat (3) @(negedge CLK);
    chk(RDY, 1'b0);
    hold = 1'b0;
    wait_on(3);
    chk(S0 | S1, 8'h00);
    // fsk parallel receive at each baud rate
    fsk8(RXBSH_B1200, TB_HZ / 1200);
    fsk8(RXBSH_B300, TB_HZ / 300);
    fsk8(RXBSH_B75, TB_HZ / 75);
    chk({7'h00, ERR}, 8'h00);
    // clock enable low: a waiting byte must not be taken
    CE = 1'b0;
    VLD = 1'b1;
    BYTE = 8'h00;
    repeat (3) @(negedge CLK);
    chk({7'h00, WE}, 8'h00);
    CE = 1'b1;
    // improper clear by the host
    bad = 1'b1;
    fill8;
    wait_on(2);
    chk(ERR, 1'b1);
    results;
  end
endmodule
`default_nettype wire
